// >>> bcm_pkg.sv
// Shared constants, register map and enumerations of the background configuration CRC monitor.
package bcm_pkg;

  // ==========================================================================
  // Register map, byte addresses on the Wishbone bus
  // ==========================================================================
  localparam int         ADR_W        = 8;
  localparam int         DAT_W        = 32;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_GOLDEN   = 8'h08;
  localparam logic [7:0] REG_LASTCRC  = 8'h0C;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_ECCONLY_BIT = 1;
  localparam int          CTRL_RATE_LSB   = 8;
  localparam int          CTRL_RATE_W     = 8;
  localparam logic [7:0]  RATE_RESET      = 8'h04;
  localparam logic [31:0] CTRL_MASK       = 32'h0000_FF03;

  // ==========================================================================
  // Status register fields
  // ==========================================================================
  localparam int STS_RUN_BIT     = 0;
  localparam int STS_GOLD_BIT    = 1;
  localparam int STS_MISM_BIT    = 2;
  localparam int STS_REL_BIT     = 3;
  localparam int STS_BLOCK_BIT   = 4;
  localparam int STS_INITPIN_BIT = 5;
  localparam int STS_CLKSRC_LSB  = 8;
  localparam int STS_PASS_LSB    = 16;
  localparam int PASS_W          = 16;

  // ==========================================================================
  // Readback geometry and CRC
  // ==========================================================================
  localparam int          FRAME_W    = 12;
  localparam int          WORD_W     = 7;
  localparam logic [11:0] LAST_FRAME = 12'h0FF;
  localparam logic [6:0]  LAST_WORD  = 7'h28;
  localparam logic [31:0] CRC_POLY   = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;
  localparam int          IR_W       = 6;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [2:0] {CLK_NONE, CLK_INTERNAL_CONFIG_ACCESS_PORT, CLK_STARTUP, CLK_MASTER, CLK_SLAVE} bcm_clksrc_e;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} bcm_state_e;

endpackage

// >>> bcm_crc_step.sv
// One 32-bit word folded into a running CRC, fully combinational.
`timescale 1ns/10ps
module bcm_crc_step #(
  parameter int          W    = 32,
  parameter logic [31:0] POLY = 32'h04C1_1DB7
) (
  // Running value and word
  input  wire logic [31:0]  crcIn,
  input  wire logic [W-1:0] dataIn,
  // Folded value
  output logic      [31:0]  crcOut
);
  always_comb begin
    logic [31:0] c;
    c = crcIn;
    for (int i = W - 1; i >= 0; i--) begin
      if (c[31] ^ dataIn[i]) begin
        c = {c[30:0], 1'b0} ^ POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    crcOut = c;
  end
endmodule

// >>> bcm_monitor.sv
// Background configuration CRC monitor with Wishbone control and status registers.
// Contract
// - Background readback runs only while the enable control bit is set.
// - Enabled logic reads configuration memory continuously and computes CRC per pass.
// - First pass result becomes golden; later passes compare against it.
// - Mismatch drives error output high and init pin low, DONE untouched.
// - Frame-check-only option keeps init pin out of error reporting.
// - Error flag holds until next comparison or new golden value.
// - Any user, JTAG or persist access halts checking and clears error.
// - Checking resumes by itself once that access ends.
// - Release command resets the checker and clears golden-valid, error flag and pass count; it sets the released flag.
// - Configuration JTAG instructions in the IR block the checker.
// - LUT memory and reconfig-port bits masked; block RAM words skipped.
// - Checking starts only after DONE high and interface released.
// - Check clock chosen: access port, startup clock, master, slave pin.
// - JTAG-only mode supplies no check clock, so nothing advances.
// - JTAG takes the configuration bus at once, preempting the checker.
// - Golden-recalculation command makes the next pass the new golden.
`timescale 1ns/10ps
module bcm_monitor #(
  // Instruction codes that claim the configuration logic; defaults are arbitrary.
  parameter logic [5:0] IR_CFG_LOAD   = 6'h05,
  parameter logic [5:0] IR_CFG_READ   = 6'h04,
  parameter logic [5:0] IR_ISP_ENABLE = 6'h10
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      srst,
  // Wishbone slave
  input  wire logic                      wbCyc,
  input  wire logic                      wbStb,
  input  wire logic                      wbWe,
  input  wire logic [bcm_pkg::ADR_W-1:0] wbAdr,
  input  wire logic [3:0]                wbSel,
  input  wire logic [bcm_pkg::DAT_W-1:0] wbDatI,
  output logic      [bcm_pkg::DAT_W-1:0] wbDatO_r,
  output logic                           wbAck_r,
  // Device options
  input  wire logic                      icapPresent,
  input  wire logic                      startupPresent,
  input  wire logic                      masterMode,
  input  wire logic                      slaveMode,
  // Candidate check clocks and DONE, all from outside this clock domain
  input  wire logic                      icapClkIn,
  input  wire logic                      userConfigClockOut,
  input  wire logic                      configClockPin,
  input  wire logic                      doneIn,
  // Configuration events and access levels
  input  wire logic                      releaseConfigCommand,
  input  wire logic                      cfgSyncSeen,
  input  wire logic                      goldenRecalcCommand,
  input  wire logic                      icapAccess,
  input  wire logic                      jtagAccess,
  input  wire logic                      persistAccess,
  input  wire logic [bcm_pkg::IR_W-1:0]  jtagIr,
  // Configuration memory readback
  output logic                           rbReq_r,
  output logic      [bcm_pkg::FRAME_W-1:0] rbFrame_r,
  output logic      [bcm_pkg::WORD_W-1:0]  rbWord_r,
  input  wire logic                      rbAck,
  input  wire logic [31:0]               rbData,
  input  wire logic [31:0]               rbMaskBits,
  input  wire logic                      rbSkip,
  // Error reporting
  output logic                           crcError_r,
  input  wire logic                      initIn,
  output logic                           initOut_r,
  output logic                           initOeN_r
);
  import bcm_pkg::*;

  // ==========================================================================
  // Input synchronisers and edge detection
  // ==========================================================================
  logic [4:0] syncA_r;
  logic [4:0] syncB_r;
  logic [4:0] syncC_r;
  logic [4:0] pinRise;

  always_ff @(posedge clk) begin
    if (srst) begin
      syncA_r <= 5'h00;
      syncB_r <= 5'h00;
      syncC_r <= 5'h00;
    end else begin
      syncA_r <= {initIn, doneIn, configClockPin, userConfigClockOut, icapClkIn};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end
  assign pinRise = syncB_r & ~syncC_r;

  // ==========================================================================
  // Control registers
  // ==========================================================================
  logic                   ctrlEn_r;
  logic                   ctrlEccOnly_r;
  logic [CTRL_RATE_W-1:0] ctrlRate_r;
  logic                   wbHit;
  logic                   wbWrite;

  assign wbHit   = wbCyc & wbStb & ~wbAck_r;
  assign wbWrite = wbHit & wbWe & (wbAdr == REG_CTRL);

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrlEn_r      <= 1'b0;
      ctrlEccOnly_r <= 1'b0;
      ctrlRate_r    <= RATE_RESET;
    end else if (wbWrite) begin
      if (wbSel[0]) begin
        ctrlEn_r      <= wbDatI[CTRL_EN_BIT];
        ctrlEccOnly_r <= wbDatI[CTRL_ECCONLY_BIT];
      end
      if (wbSel[1]) begin
        ctrlRate_r <= wbDatI[CTRL_RATE_LSB +: CTRL_RATE_W];
      end
    end
  end

  // ==========================================================================
  // Check clock selection
  // ==========================================================================
  bcm_clksrc_e            clkSrc;
  logic [CTRL_RATE_W-1:0] divCnt_r;
  logic                   masterTick_r;
  logic                   checkTick;

  always_comb begin
    if (icapPresent) begin
      clkSrc = CLK_INTERNAL_CONFIG_ACCESS_PORT;
    end else if (startupPresent) begin
      clkSrc = CLK_STARTUP;
    end else if (masterMode) begin
      clkSrc = CLK_MASTER;
    end else if (slaveMode) begin
      clkSrc = CLK_SLAVE;
    end else begin
      clkSrc = CLK_NONE;
    end
  end

  // The master clock is modelled as a divider so its rate follows the rate field.
  always_ff @(posedge clk) begin
    if (srst) begin
      divCnt_r     <= '0;
      masterTick_r <= 1'b0;
    end else if (divCnt_r >= ctrlRate_r) begin
      divCnt_r     <= '0;
      masterTick_r <= 1'b1;
    end else begin
      divCnt_r     <= divCnt_r + 8'h01;
      masterTick_r <= 1'b0;
    end
  end

  always_comb begin
    case (clkSrc)
      CLK_INTERNAL_CONFIG_ACCESS_PORT:    checkTick = pinRise[0];
      CLK_STARTUP: checkTick = pinRise[1];
      CLK_MASTER:  checkTick = masterTick_r;
      CLK_SLAVE:   checkTick = pinRise[2];
      default:     checkTick = 1'b0;
    endcase
  end

  // ==========================================================================
  // Access arbitration
  // ==========================================================================
  logic released_r;
  logic irCfg;
  logic haltAccess;
  logic allowed;

  // A fresh configuration session takes the interface until it is released again.
  always_ff @(posedge clk) begin
    if (srst) begin
      released_r <= 1'b0;
    end else if (releaseConfigCommand) begin
      released_r <= 1'b1;
    end else if (cfgSyncSeen) begin
      released_r <= 1'b0;
    end
  end

  assign irCfg      = (jtagIr == IR_CFG_LOAD) | (jtagIr == IR_CFG_READ) | (jtagIr == IR_ISP_ENABLE);
  assign haltAccess = icapAccess | jtagAccess | persistAccess | irCfg;
  assign allowed    = ctrlEn_r & syncB_r[3] & released_r & ~haltAccess;

  // ==========================================================================
  // Readback walker
  // ==========================================================================
  bcm_state_e  state_r;
  logic [31:0] crcAcc_r;
  logic [31:0] crcFold;
  logic [31:0] crcNext;
  logic        passDone_r;
  logic [31:0] passCrc_r;
  logic        lastWord;

  bcm_crc_step #(
    .W    (32),
    .POLY (CRC_POLY)
  ) uCrcStep (
    .crcIn  (crcAcc_r),
    .dataIn (rbData & ~rbMaskBits),
    .crcOut (crcFold)
  );

  assign crcNext  = rbSkip ? crcAcc_r : crcFold;
  assign lastWord = (rbFrame_r == LAST_FRAME) & (rbWord_r == LAST_WORD);

  // Dropping the request on halt hands the bus back at once; a pending read is abandoned.
  always_ff @(posedge clk) begin
    if (srst | releaseConfigCommand | ~allowed) begin
      state_r   <= ST_IDLE;
      rbReq_r   <= 1'b0;
      rbFrame_r <= '0;
      rbWord_r  <= '0;
      crcAcc_r  <= CRC_INIT;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_r <= ST_REQ;
        end
        ST_REQ: begin
          if (checkTick) begin
            rbReq_r <= 1'b1;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rbAck) begin
            rbReq_r <= 1'b0;
            state_r <= ST_REQ;
            if (lastWord) begin
              rbFrame_r <= '0;
              rbWord_r  <= '0;
              crcAcc_r  <= CRC_INIT;
            end else if (rbWord_r == LAST_WORD) begin
              rbFrame_r <= rbFrame_r + 12'h001;
              rbWord_r  <= '0;
              crcAcc_r  <= crcNext;
            end else begin
              rbWord_r <= rbWord_r + 7'h01;
              crcAcc_r <= crcNext;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst | releaseConfigCommand | ~allowed) begin
      passDone_r <= 1'b0;
      passCrc_r  <= '0;
    end else begin
      passDone_r <= (state_r == ST_WAIT) & rbAck & lastWord;
      if ((state_r == ST_WAIT) & rbAck & lastWord) begin
        passCrc_r <= crcNext;
      end
    end
  end

  // ==========================================================================
  // Golden value and mismatch flag
  // ==========================================================================
  logic [31:0]       golden_r;
  logic              goldValid_r;
  logic              recalcPend_r;
  logic              newGold;
  logic              mismSet;
  logic [PASS_W-1:0] passCount_r;
  logic [31:0]       lastCrc_r;

  assign newGold = passDone_r & (~goldValid_r | recalcPend_r);
  assign mismSet = passDone_r & goldValid_r & ~recalcPend_r & (passCrc_r != golden_r);

  always_ff @(posedge clk) begin
    if (srst | releaseConfigCommand) begin
      golden_r    <= '0;
      goldValid_r <= 1'b0;
    end else if (newGold) begin
      golden_r    <= passCrc_r;
      goldValid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      recalcPend_r <= 1'b0;
    end else if (goldenRecalcCommand) begin
      recalcPend_r <= 1'b1;
    end else if (newGold | releaseConfigCommand) begin
      recalcPend_r <= 1'b0;
    end
  end

  // A new mismatch wins over any clear arriving in the same cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      crcError_r <= 1'b0;
    end else if (mismSet) begin
      crcError_r <= 1'b1;
    end else if (releaseConfigCommand | haltAccess | newGold | passDone_r) begin
      crcError_r <= 1'b0;
    end
  end

  // The init pin is open drain: only ever pulled low, DONE is never touched here.
  always_ff @(posedge clk) begin
    if (srst) begin
      initOut_r <= 1'b0;
      initOeN_r <= 1'b1;
    end else begin
      initOut_r <= 1'b0;
      initOeN_r <= ~(crcError_r & ~ctrlEccOnly_r);
    end
  end

  always_ff @(posedge clk) begin
    if (srst | releaseConfigCommand) begin
      passCount_r <= '0;
      lastCrc_r   <= '0;
    end else if (passDone_r) begin
      passCount_r <= passCount_r + 16'h0001;
      lastCrc_r   <= passCrc_r;
    end
  end

  // ==========================================================================
  // Wishbone read path and acknowledge
  // ==========================================================================
  logic [31:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[STS_RUN_BIT]     = (state_r != ST_IDLE);
    statusWord[STS_GOLD_BIT]    = goldValid_r;
    statusWord[STS_MISM_BIT]    = crcError_r;
    statusWord[STS_REL_BIT]     = released_r;
    statusWord[STS_BLOCK_BIT]   = haltAccess;
    statusWord[STS_INITPIN_BIT] = syncB_r[4];
    statusWord[STS_CLKSRC_LSB +: 3]     = clkSrc;
    statusWord[STS_PASS_LSB +: PASS_W]  = passCount_r;
  end

  // Unmapped addresses are acknowledged and read as zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      wbAck_r  <= 1'b0;
      wbDatO_r <= '0;
    end else begin
      wbAck_r <= wbHit;
      if (wbHit) begin
        case (wbAdr)
          REG_CTRL:    wbDatO_r <= {16'h0000, ctrlRate_r, 6'h00, ctrlEccOnly_r, ctrlEn_r} & CTRL_MASK;
          REG_STATUS:  wbDatO_r <= statusWord;
          REG_GOLDEN:  wbDatO_r <= golden_r;
          REG_LASTCRC: wbDatO_r <= lastCrc_r;
          default:     wbDatO_r <= '0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_disabled_idle: assert property (@(posedge clk) disable iff (srst) !ctrlEn_r |=> !rbReq_r)
    else $error("readback requested while disabled");
  a_golden_latch: assert property (@(posedge clk) disable iff (srst)
    passDone_r && !goldValid_r && !releaseConfigCommand |=> goldValid_r && golden_r == $past(passCrc_r))
    else $error("first pass not latched as golden");
  a_mismatch_flag: assert property (@(posedge clk) disable iff (srst) mismSet |=> crcError_r)
    else $error("mismatch did not raise error");
  a_init_low: assert property (@(posedge clk) disable iff (srst)
    crcError_r && !ctrlEccOnly_r |=> !initOeN_r && !initOut_r)
    else $error("init pin not pulled low on error");
  a_ecc_only: assert property (@(posedge clk) disable iff (srst) ctrlEccOnly_r |=> initOeN_r)
    else $error("init pin driven in frame-check-only mode");
  a_error_hold: assert property (@(posedge clk) disable iff (srst)
    crcError_r && !passDone_r && !haltAccess && !releaseConfigCommand |=> crcError_r)
    else $error("error flag dropped early");
  a_halt_clear: assert property (@(posedge clk) disable iff (srst)
    haltAccess && !mismSet |=> !crcError_r && !rbReq_r)
    else $error("access did not halt checker");
  a_release_reset: assert property (@(posedge clk) disable iff (srst)
    releaseConfigCommand && !mismSet |=> !goldValid_r && !crcError_r && state_r == ST_IDLE)
    else $error("release command did not reset checker");
  a_ir_block: assert property (@(posedge clk) disable iff (srst) irCfg [*2] |-> !rbReq_r)
    else $error("readback ran with configuration instruction loaded");
  a_done_gate: assert property (@(posedge clk) disable iff (srst) !syncB_r[3] |=> !rbReq_r && !passDone_r)
    else $error("readback before DONE");
  a_clock_prio: assert property (@(posedge clk) disable iff (srst)
    icapPresent |-> clkSrc == CLK_INTERNAL_CONFIG_ACCESS_PORT)
    else $error("access port clock not preferred");
  a_no_clock: assert property (@(posedge clk) disable iff (srst)
    clkSrc == CLK_NONE && state_r == ST_REQ |=> !rbReq_r)
    else $error("checker advanced without a clock");
  a_pass_wrap: assert property (@(posedge clk) disable iff (srst)
    passDone_r |-> rbFrame_r == '0 && rbWord_r == '0)
    else $error("pass did not restart at first frame");
  a_resume: assert property (@(posedge clk) disable iff (srst)
    allowed && !releaseConfigCommand && state_r == ST_IDLE ##1 allowed |-> state_r == ST_REQ)
    else $error("checker did not resume");

  c_golden: cover property (@(posedge clk) disable iff (srst) newGold);
  c_mismatch: cover property (@(posedge clk) disable iff (srst) mismSet);
  c_halt_wait: cover property (@(posedge clk) disable iff (srst) state_r == ST_WAIT ##1 haltAccess);
  c_recalc: cover property (@(posedge clk) disable iff (srst) recalcPend_r && passDone_r);
endmodule

// >>> bcm_mem_model.sv
// Behavioural configuration memory answering readback requests of the monitor.
`timescale 1ns/10ps
module bcm_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Readback request
  input  wire logic        rbReq,
  input  wire logic [11:0] rbFrame,
  input  wire logic [6:0]  rbWord,
  // Behaviour controls
  input  wire logic        slow,
  input  wire logic        upset,
  // Answer
  output logic             rbAck,
  output logic [31:0]      rbData,
  output logic [31:0]      rbMaskBits,
  output logic             rbSkip
);
  logic [1:0]  waitCnt_r;
  logic [31:0] word;
  // ==========
  // Content: word 1 holds masked lut memory, word 2 stands for block RAM.
  always_comb begin
    word = {rbFrame, 13'h0, rbWord};
    if (upset && rbWord == 7'h01) word = word ^ 32'hF000_0000;
    if (upset && rbWord == 7'h02) word = ~word;
    if (upset && rbWord == 7'h03 && rbFrame == 12'h010) word = word ^ 32'h1;
  end
  // ==========
  // Answer; lines off the handshake show the inverse so no stale value passes.
  always_ff @(posedge clk) begin
    rbAck <= 1'h0;
    rbData <= srst ? 32'h0 : ~rbData;
    rbMaskBits <= srst ? 32'h0 : ~rbMaskBits;
    rbSkip <= srst ? 1'h0 : ~rbSkip;
    if (srst || !rbReq || rbAck) begin
      waitCnt_r <= slow ? 2'h3 : 2'h0;
    end else if (waitCnt_r != 2'h0) begin
      waitCnt_r <= waitCnt_r - 2'h1;
    end else begin
      rbAck <= 1'h1;
      rbData <= word;
      rbMaskBits <= (rbWord == 7'h01) ? 32'hF000_0000 : 32'h0;
      rbSkip <= (rbWord == 7'h02);
    end
  end
endmodule

// >>> bcm_monitor_bench.sv
// Self-checking bench of the background configuration CRC monitor.
`timescale 1ns/10ps
module bcm_monitor_bench;
  import bcm_pkg::*;
  localparam logic [5:0] IR_LD = 6'h05;
  localparam logic [5:0] IR_RD = 6'h04;
  localparam logic [5:0] IR_ISP = 6'h10;
  logic        clk, srst = 1'h1, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO_r, rbData, rbMaskBits;
  logic        wbAck_r, rbReq_r, rbAck, rbSkip, crcError_r, initOut_r, initOeN_r;
  logic [11:0] rbFrame_r;
  logic [6:0]  rbWord_r;
  logic        icapPresent = 1'h0, startupPresent = 1'h0, masterMode = 1'h0, slaveMode = 1'h0;
  logic        doneIn = 1'h0, releaseConfigCommand = 1'h0, cfgSyncSeen = 1'h0, slow = 1'h0;
  logic        goldenRecalcCommand = 1'h0, pinClk = 1'h0;
  logic        icapAccess = 1'h0, jtagAccess = 1'h0, persistAccess = 1'h0, upset = 1'h0;
  logic [5:0]  jtagIr = 6'h3F;
  int          errors = 0, tests_run = 0;
  // ==========
  // Instances; one free-running pin clock feeds all candidates, the init pin reads back via its pull-up.
  bcm_monitor #(.IR_CFG_LOAD(IR_LD), .IR_CFG_READ(IR_RD), .IR_ISP_ENABLE(IR_ISP)) dut_u (
    .clk, .srst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO_r, .wbAck_r,
    .icapPresent, .startupPresent, .masterMode, .slaveMode, .icapClkIn(pinClk),
    .userConfigClockOut(pinClk), .configClockPin(pinClk), .doneIn, .releaseConfigCommand,
    .cfgSyncSeen, .goldenRecalcCommand, .icapAccess, .jtagAccess, .persistAccess,
    .jtagIr, .rbReq_r, .rbFrame_r, .rbWord_r, .rbAck, .rbData, .rbMaskBits, .rbSkip,
    .crcError_r, .initIn(initOeN_r | initOut_r), .initOut_r, .initOeN_r);
  bcm_mem_model mem_u (.clk, .srst, .rbReq(rbReq_r), .rbFrame(rbFrame_r), .rbWord(rbWord_r),
    .slow, .upset, .rbAck, .rbData, .rbMaskBits, .rbSkip);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) pinClk <= ~pinClk;
  // ==========
  // Shared tasks
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatI <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck_r !== 1'h1 && n < 50);
    rd = wbDatO_r;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    if (n >= 50) check("wb ack", 32'h0, 32'h1);
  endtask
  task automatic pulse(int sync);
    @(posedge clk);
    if (sync == 1) cfgSyncSeen <= 1'h1;
    else if (sync == 2) goldenRecalcCommand <= 1'h1;
    else releaseConfigCommand <= 1'h1;
    @(posedge clk);
    cfgSyncSeen <= 1'h0;
    releaseConfigCommand <= 1'h0;
    goldenRecalcCommand <= 1'h0;
  endtask
  task automatic wait_req(int lim, output bit got);
    got = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      if (rbReq_r === 1'h1) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  // ==========
  // Scenarios
  task automatic s_reset;
    logic [31:0] d;
    wb(1'h0, REG_CTRL, 32'h0, d);
    check("ctrl", d, {16'h0, RATE_RESET, 8'h00});
    wb(1'h1, REG_STATUS, 32'hFFFF_FFFF, d);
    wb(1'h0, REG_STATUS, 32'h0, d);
    check("status", d, 32'h20);
    wb(1'h0, 8'h10, 32'h0, d);
    check("unmapped", d, 32'h0);
    check("pins", {rbReq_r, crcError_r, initOut_r, initOeN_r}, 32'h1);
  endtask
  task automatic s_clksrc;
    logic [31:0] d;
    logic [3:0]  opt [5] = '{4'hF, 4'h7, 4'h2, 4'h1, 4'h0};
    for (int i = 0; i < 5; i++) begin
      {icapPresent, startupPresent, masterMode, slaveMode} <= opt[i];
      wb(1'h0, REG_STATUS, 32'h0, d);
      check("clock source", d[10:8], 32'((i + 1) % 5));
    end
  endtask
  task automatic s_gate;
    logic [31:0] d;
    bit          g;
    masterMode <= 1'h1;
    doneIn <= 1'h1;
    wb(1'h1, REG_CTRL, 32'h1, d);
    wait_req(60, g);
    check("unreleased", g, 0);
    doneIn <= 1'h0;
    pulse(0);
    wait_req(60, g);
    check("not done", g, 0);
    wb(1'h1, REG_CTRL, 32'h0, d);
    doneIn <= 1'h1;
    wait_req(60, g);
    check("disabled", g, 0);
    masterMode <= 1'h0;
    wb(1'h1, REG_CTRL, 32'h1, d);
    wait_req(60, g);
    check("no clock", g, 0);
    icapPresent <= 1'h1;
    wait_req(60, g);
    check("port clock", g, 1);
    icapPresent <= 1'h0;
    masterMode <= 1'h1;
    for (int w = 0; w < 3; w++) begin
      wait_req(100, g);
      check("order", {g, rbFrame_r, rbWord_r}, {1'h1, 12'h0, 7'(w)});
      while (rbReq_r === 1'h1) @(posedge clk);
    end
    pulse(1);
    wait_req(60, g);
    check("session", g, 0);
    pulse(0);
  endtask
  task automatic s_halt;
    logic [31:0] d;
    bit          g;
    logic [5:0]  ir [3] = '{IR_LD, IR_RD, IR_ISP};
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      wait_req(100, g);
      icapAccess <= (i == 0);
      jtagAccess <= (i == 1);
      persistAccess <= (i == 2);
      jtagIr <= (i > 2) ? ir[i % 3] : 6'h3F;
      tick(3);
      wb(1'h0, REG_STATUS, 32'h0, d);
      check("halted", {rbReq_r, d[STS_BLOCK_BIT]}, 32'h1);
      wait_req(40, g);
      check("held", g, 0);
      icapAccess <= 1'h0;
      jtagAccess <= 1'h0;
      persistAccess <= 1'h0;
      jtagIr <= 6'h3F;
      wait_req(100, g);
      check("resume", {g, rbFrame_r, rbWord_r}, {1'h1, 19'h0});
    end
  endtask
  task automatic s_passes;
    logic [31:0] d;
    int          n;
    logic [31:0] g1;
    n = 0;
    slow <= 1'h0;
    do begin
      wb(1'h0, REG_STATUS, 32'h0, d);
      n++;
    end while (d[STS_GOLD_BIT] !== 1'h1 && n < 30000);
    upset <= 1'h1;
    check("golden", {crcError_r, d[STS_GOLD_BIT]}, 32'h1);
    wb(1'h0, REG_GOLDEN, 32'h0, g1);
    pulse(2);
    n = 0;
    do begin
      wb(1'h0, REG_GOLDEN, 32'h0, d);
      n++;
    end while (d === g1 && n < 30000);
    upset <= 1'h0;
    check("recalc", {crcError_r, d !== g1}, 32'h1);
    n = 0;
    while (crcError_r !== 1'h1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    tick(2);
    check("mismatch", {crcError_r, initOeN_r, initOut_r, doneIn}, 32'h9);
    wb(1'h0, REG_STATUS, 32'h0, d);
    check("err status", {d[STS_INITPIN_BIT], d[STS_MISM_BIT]}, 32'h1);
    wb(1'h1, REG_CTRL, 32'h3, d);
    tick(1);
    check("frame check only", {crcError_r, initOeN_r}, 32'h3);
    wb(1'h1, REG_CTRL, 32'h1, d);
    n = 0;
    repeat (50) begin
      @(posedge clk);
      if (crcError_r === 1'h1) n++;
    end
    check("flag hold", n, 50);
    upset <= 1'h0;
    pulse(0);
    tick(2);
    wb(1'h0, REG_STATUS, 32'h0, d);
    check("cleared", {crcError_r, initOeN_r, d[31:16], d[2:1]}, {2'h1, 18'h0});
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    s_reset;
    s_clksrc;
    s_gate;
    s_halt;
    s_passes;
    summarize;
  end
  initial begin
    repeat (99000) @(posedge clk);
    errors++;
    summarize;
  end
endmodule
